// *** pkg/cvj_pkg.sv ***
/*
 * Constants shared by the codec volume, jack and ADC control register bank.
 * Assumes a 32-bit AHB-Lite bus where each register takes one word at four times its index.
 */
package cvj_pkg;
   // Register indices; the byte address is four times the index.
   localparam logic [5:0] IDX_JACK_SEL = 6'h09;
   localparam logic [5:0] IDX_LDAC_VOL = 6'h0b;
   localparam logic [5:0] IDX_RDAC_VOL = 6'h0c;
   localparam logic [5:0] IDX_JACK_OEN = 6'h0d;
   localparam logic [5:0] IDX_ADC_CTRL = 6'h0e;
   localparam logic [5:0] IDX_LADC_VOL = 6'h0f;
   localparam logic [5:0] IDX_RADC_VOL = 6'h10;

   // Register width and volume word layout.
   localparam int REG_W = 9;
   localparam int GAIN_W = 8;
   localparam int VU_BIT = 8;
   localparam logic [7:0] GAIN_RST = 8'hff;
   localparam logic [7:0] GAIN_MUTE = 8'h00;

   // Jack output enable word: high-level group and low-level group.
   localparam int JCK_HI_LSB = 4;
   localparam int JCK_LO_LSB = 0;
   localparam int JCK_GRP_W = 4;
   localparam logic [7:0] JCK_OEN_RST = 8'h00;

   // Jack select word.
   localparam int JSEL_ON_BIT = 6;
   localparam int JSEL_LSB = 4;
   localparam int JSEL_W = 2;
   localparam logic [1:0] JSEL_RSVD = 2'b11;
   localparam int NUM_DET_PINS = 3;

   // ADC control word.
   localparam int ADC_HPF_ON_BIT = 8;
   localparam int ADC_HPF_MODE_BIT = 7;
   localparam int ADC_CUT_LSB = 4;
   localparam int ADC_CUT_W = 3;
   localparam int ADC_OS_BIT = 3;
   localparam int ADC_RINV_BIT = 1;
   localparam int ADC_LINV_BIT = 0;
   localparam logic [8:0] ADC_CTRL_RST = 9'h100;

   // AHB-Lite encodings.
   localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
   localparam logic [2:0] HSIZE_WORD = 3'b010;
   localparam logic HRESP_OKAY = 1'b0;
endpackage : cvj_pkg

// *** src/cvj_regs.sv ***
/*
 * Volume, jack output enable and ADC control registers behind an AHB-Lite slave,
 * with the ADC sample polarity stage.
 * Assumes one clock, inputs synchronous to it, and ADC samples arriving with a valid strobe.
 */
// The AHB-Lite slave port was chosen for this implementation.
module cvj_regs #(
   parameter int SAMPLE_W = 24
) (
   // Clock and reset.
   input wire logic i_ref_clk,
   input wire logic i_rst,
   // AHB-Lite slave.
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic o_hreadyout,
   output logic o_hresp,
   output logic [31:0] o_hrdata,
   // Jack detect pins.
   input wire logic i_general_pin_one,
   input wire logic i_general_pin_two,
   input wire logic i_general_pin_three,
   // Output driver enables.
   output logic o_headphone_en,
   output logic o_speaker_en,
   output logic o_aux_line_out_two_en,
   output logic o_aux_line_out_one_en,
   // Active gains and mutes.
   output logic [7:0] o_right_dac_attenuation,
   output logic [7:0] o_left_dac_attenuation,
   output logic [7:0] o_left_adc_attenuation,
   output logic [7:0] o_right_adc_attenuation,
   output logic o_right_dac_mute,
   output logic o_left_dac_mute,
   output logic o_left_adc_mute,
   output logic o_right_adc_mute,
   // ADC filter and rate controls.
   output logic o_adc_highpass_on,
   output logic o_adc_highpass_mode,
   output logic [2:0] o_adc_highpass_cutoff,
   output logic o_adc_oversample_select,
   // ADC sample path.
   input wire logic i_adc_valid,
   input wire logic [SAMPLE_W-1:0] i_left_adc_sample,
   input wire logic [SAMPLE_W-1:0] i_right_adc_sample,
   output logic o_adc_valid,
   output logic [SAMPLE_W-1:0] o_left_adc_sample,
   output logic [SAMPLE_W-1:0] o_right_adc_sample
);

   if (SAMPLE_W < 2) begin : g_bad_width
      $error("SAMPLE_W must be at least 2.");
   end

   // Field layout checks against the package.
   if (cvj_pkg::VU_BIT != cvj_pkg::GAIN_W) begin : g_bad_vu
      $error("Commit bit must sit just above the gain field.");
   end
   if (cvj_pkg::REG_W != cvj_pkg::VU_BIT + 1) begin : g_bad_reg
      $error("Register width must end at the commit bit.");
   end
   if (2 * cvj_pkg::JCK_GRP_W != cvj_pkg::GAIN_W) begin : g_bad_jack
      $error("Jack enable groups must fill one byte.");
   end
   if (cvj_pkg::NUM_DET_PINS != 3) begin : g_bad_pins
      $error("Three detect pins are wired.");
   end

   localparam logic [SAMPLE_W-1:0] SMP_MIN = {1'b1, {(SAMPLE_W-1){1'b0}}};
   localparam logic [SAMPLE_W-1:0] SMP_MAX = {1'b0, {(SAMPLE_W-1){1'b1}}};

   // Bus pipeline state.
   logic wr_pend_q;
   logic rd_pend_q;
   logic [5:0] idx_q;
   logic addr_ok_q;

   // Stored and active gains.
   logic [7:0] rdac_buf_q;
   logic [7:0] ldac_buf_q;
   logic [7:0] ladc_buf_q;
   logic [7:0] radc_buf_q;
   logic [7:0] rdac_act_q;
   logic [7:0] ldac_act_q;
   logic [7:0] ladc_act_q;
   logic [7:0] radc_act_q;

   // Control words.
   logic [7:0] jack_oen_q;
   logic jack_on_q;
   logic [1:0] jack_sel_q;
   logic [8:0] adc_ctrl_q;

   // Drive enable state seen by software.
   logic [3:0] drive_q;

   // Address phase and write strobe decode.
   logic take;
   logic [5:0] a_idx;
   logic a_ok;
   logic a_high_zero;
   logic a_aligned;
   logic a_word;
   logic wr_now;
   logic [8:0] wd;
   logic commit;

   assign take = i_hsel && (i_htrans == cvj_pkg::HTRANS_NONSEQ) && i_hready;
   assign a_idx = i_haddr[7:2];
   assign a_high_zero = (i_haddr[31:8] == 24'h00_0000);
   assign a_aligned = (i_haddr[1:0] == 2'b00);
   assign a_word = (i_hsize == cvj_pkg::HSIZE_WORD);
   assign a_ok = a_high_zero && a_aligned && a_word;
   assign wr_now = wr_pend_q && addr_ok_q;
   assign wd = i_hwdata[cvj_pkg::REG_W-1:0];
   assign commit = wd[cvj_pkg::VU_BIT];

   // Bus handshake: writes finish with no wait state, reads take one.
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         wr_pend_q <= 1'b0;
         rd_pend_q <= 1'b0;
         idx_q <= 6'h00;
         addr_ok_q <= 1'b0;
         o_hreadyout <= 1'b1;
         o_hresp <= cvj_pkg::HRESP_OKAY;
      end else begin
         o_hresp <= cvj_pkg::HRESP_OKAY;
         if (rd_pend_q) begin
            rd_pend_q <= 1'b0;
            o_hreadyout <= 1'b1;
         end else begin
            wr_pend_q <= take && i_hwrite;
            rd_pend_q <= take && !i_hwrite;
            o_hreadyout <= !(take && !i_hwrite);
            if (take) begin
               idx_q <= a_idx;
               addr_ok_q <= a_ok;
            end
         end
      end
   end

   // Read data, taken after any preceding write has landed.
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_hrdata <= 32'h0000_0000;
      end else if (rd_pend_q) begin
         o_hrdata <= 32'h0000_0000;
         if (addr_ok_q) begin
            case (idx_q)
               cvj_pkg::IDX_JACK_SEL: o_hrdata[7:0] <= {1'b0, jack_on_q, jack_sel_q, drive_q};
               cvj_pkg::IDX_LDAC_VOL: o_hrdata[7:0] <= ldac_buf_q;
               cvj_pkg::IDX_RDAC_VOL: o_hrdata[7:0] <= rdac_buf_q;
               cvj_pkg::IDX_JACK_OEN: o_hrdata[7:0] <= jack_oen_q;
               cvj_pkg::IDX_ADC_CTRL: o_hrdata[8:0] <= adc_ctrl_q;
               cvj_pkg::IDX_LADC_VOL: o_hrdata[7:0] <= ladc_buf_q;
               cvj_pkg::IDX_RADC_VOL: o_hrdata[7:0] <= radc_buf_q;
               default: o_hrdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // DAC volume pair: writes buffer, a commit bit moves both to the active path.
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         rdac_buf_q <= cvj_pkg::GAIN_RST;
         ldac_buf_q <= cvj_pkg::GAIN_RST;
         rdac_act_q <= cvj_pkg::GAIN_RST;
         ldac_act_q <= cvj_pkg::GAIN_RST;
      end else if (wr_now && (idx_q == cvj_pkg::IDX_RDAC_VOL)) begin
         rdac_buf_q <= wd[cvj_pkg::GAIN_W-1:0];
         if (commit) begin
            rdac_act_q <= wd[cvj_pkg::GAIN_W-1:0];
            ldac_act_q <= ldac_buf_q;
         end
      end else if (wr_now && (idx_q == cvj_pkg::IDX_LDAC_VOL)) begin
         ldac_buf_q <= wd[cvj_pkg::GAIN_W-1:0];
         if (commit) begin
            ldac_act_q <= wd[cvj_pkg::GAIN_W-1:0];
            rdac_act_q <= rdac_buf_q;
         end
      end
   end

   // ADC volume pair: same buffering and commit scheme.
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         ladc_buf_q <= cvj_pkg::GAIN_RST;
         radc_buf_q <= cvj_pkg::GAIN_RST;
         ladc_act_q <= cvj_pkg::GAIN_RST;
         radc_act_q <= cvj_pkg::GAIN_RST;
      end else if (wr_now && (idx_q == cvj_pkg::IDX_LADC_VOL)) begin
         ladc_buf_q <= wd[cvj_pkg::GAIN_W-1:0];
         if (commit) begin
            ladc_act_q <= wd[cvj_pkg::GAIN_W-1:0];
            radc_act_q <= radc_buf_q;
         end
      end else if (wr_now && (idx_q == cvj_pkg::IDX_RADC_VOL)) begin
         radc_buf_q <= wd[cvj_pkg::GAIN_W-1:0];
         if (commit) begin
            radc_act_q <= wd[cvj_pkg::GAIN_W-1:0];
            ladc_act_q <= ladc_buf_q;
         end
      end
   end

   // Jack and ADC control words.
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         jack_oen_q <= cvj_pkg::JCK_OEN_RST;
         jack_on_q <= 1'b0;
         jack_sel_q <= 2'b00;
         adc_ctrl_q <= cvj_pkg::ADC_CTRL_RST;
      end else if (wr_now) begin
         case (idx_q)
            cvj_pkg::IDX_JACK_OEN: jack_oen_q <= wd[7:0];
            cvj_pkg::IDX_JACK_SEL: begin
               jack_on_q <= wd[cvj_pkg::JSEL_ON_BIT];
               jack_sel_q <= wd[cvj_pkg::JSEL_LSB +: cvj_pkg::JSEL_W];
            end
            cvj_pkg::IDX_ADC_CTRL: adc_ctrl_q <= wd;
            default: jack_on_q <= jack_on_q;
         endcase
      end
   end

   // Jack detect pin selection and driver enables.
   logic [cvj_pkg::NUM_DET_PINS-1:0] det_pins;
   logic det_level;
   logic sel_valid;
   assign det_pins = {i_general_pin_three, i_general_pin_two, i_general_pin_one};
   assign sel_valid = (jack_sel_q != cvj_pkg::JSEL_RSVD);
   assign det_level = sel_valid ? det_pins[jack_sel_q] : 1'b0;

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         drive_q <= 4'h0;
      end else if (!jack_on_q || !sel_valid) begin
         drive_q <= 4'h0;
      end else if (det_level) begin
         drive_q <= jack_oen_q[cvj_pkg::JCK_HI_LSB +: cvj_pkg::JCK_GRP_W];
      end else begin
         drive_q <= jack_oen_q[cvj_pkg::JCK_LO_LSB +: cvj_pkg::JCK_GRP_W];
      end
   end

   assign o_headphone_en = drive_q[0];
   assign o_speaker_en = drive_q[1];
   assign o_aux_line_out_two_en = drive_q[2];
   assign o_aux_line_out_one_en = drive_q[3];

   // Gain and mute outputs follow the active gains one cycle later.
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_right_dac_attenuation <= cvj_pkg::GAIN_RST;
         o_left_dac_attenuation <= cvj_pkg::GAIN_RST;
         o_left_adc_attenuation <= cvj_pkg::GAIN_RST;
         o_right_adc_attenuation <= cvj_pkg::GAIN_RST;
         o_right_dac_mute <= 1'b0;
         o_left_dac_mute <= 1'b0;
         o_left_adc_mute <= 1'b0;
         o_right_adc_mute <= 1'b0;
      end else begin
         o_right_dac_attenuation <= rdac_act_q;
         o_left_dac_attenuation <= ldac_act_q;
         o_left_adc_attenuation <= ladc_act_q;
         o_right_adc_attenuation <= radc_act_q;
         o_right_dac_mute <= (rdac_act_q == cvj_pkg::GAIN_MUTE);
         o_left_dac_mute <= (ldac_act_q == cvj_pkg::GAIN_MUTE);
         o_left_adc_mute <= (ladc_act_q == cvj_pkg::GAIN_MUTE);
         o_right_adc_mute <= (radc_act_q == cvj_pkg::GAIN_MUTE);
      end
   end

   // Filter and rate controls.
   logic hpf_on;
   logic hpf_mode;
   assign hpf_on = adc_ctrl_q[cvj_pkg::ADC_HPF_ON_BIT];
   assign hpf_mode = adc_ctrl_q[cvj_pkg::ADC_HPF_MODE_BIT];

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_adc_highpass_on <= cvj_pkg::ADC_CTRL_RST[cvj_pkg::ADC_HPF_ON_BIT];
         o_adc_highpass_mode <= 1'b0;
         o_adc_highpass_cutoff <= 3'b000;
         o_adc_oversample_select <= 1'b0;
      end else begin
         o_adc_highpass_on <= hpf_on;
         o_adc_highpass_mode <= hpf_mode;
         o_adc_highpass_cutoff <= (hpf_on && hpf_mode) ?
            adc_ctrl_q[cvj_pkg::ADC_CUT_LSB +: cvj_pkg::ADC_CUT_W] : 3'b000;
         o_adc_oversample_select <= adc_ctrl_q[cvj_pkg::ADC_OS_BIT];
      end
   end

   // Polarity stage; the most negative code saturates to the most positive.
   function automatic logic [SAMPLE_W-1:0] negate(input logic [SAMPLE_W-1:0] s);
      logic [SAMPLE_W-1:0] r;
      r = (s == SMP_MIN) ? SMP_MAX : (~s + {{(SAMPLE_W-1){1'b0}}, 1'b1});
      return r;
   endfunction : negate

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_adc_valid <= 1'b0;
         o_left_adc_sample <= '0;
         o_right_adc_sample <= '0;
      end else begin
         o_adc_valid <= i_adc_valid;
         if (i_adc_valid) begin
            o_left_adc_sample <= adc_ctrl_q[cvj_pkg::ADC_LINV_BIT] ?
               negate(i_left_adc_sample) : i_left_adc_sample;
            o_right_adc_sample <= adc_ctrl_q[cvj_pkg::ADC_RINV_BIT] ?
               negate(i_right_adc_sample) : i_right_adc_sample;
         end
      end
   end

endmodule : cvj_regs

// *** tb/cvj_host.sv ***
/* Host model that drives the bank's AHB-Lite port with single word transfers.
   Assumes one slave whose hreadyout is fed back as hready. */
module cvj_host (
   // Clock and answer.
   input wire logic i_ref_clk,
   input wire logic i_hready,
   input wire logic [31:0] i_hrdata,
   // Request.
   output logic o_hsel,
   output logic [31:0] o_haddr,
   output logic [1:0] o_htrans,
   output logic o_hwrite,
   output logic [2:0] o_hsize,
   output logic [31:0] o_hwdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      o_hsel = 1'b0;
      o_haddr = 32'h0000_0000;
      o_htrans = 2'b00;
      o_hwrite = 1'b0;
      o_hsize = cvj_pkg::HSIZE_WORD;
      o_hwdata = 32'h0000_0000;
   end
   // Released lines show inverted values so stale data never passes.
   task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic ok);
      int n;
      n = 0;
      @(posedge i_ref_clk);
      o_hsel <= 1'b1;
      o_haddr <= a;
      o_htrans <= cvj_pkg::HTRANS_NONSEQ;
      o_hwrite <= wr;
      do begin
         @(posedge i_ref_clk);
         n++;
      end while (i_hready !== 1'b1 && n < 64);
      ok = (i_hready === 1'b1);
      o_hsel <= 1'b0;
      o_htrans <= 2'b00;
      o_haddr <= ~a;
      o_hwrite <= ~wr;
      o_hwdata <= wr ? d : ~d;
      do begin
         @(posedge i_ref_clk);
         n++;
      end while (i_hready !== 1'b1 && n < 128);
      r = i_hrdata;
      ok = ok && (i_hready === 1'b1);
      o_hwdata <= ~d;
   endtask : xfer
endmodule : cvj_host

// *** tb/cvj_regs_sva.sv ***
/* Concurrent checks on the volume, jack and ADC control bank.
   Assumes it is bound to cvj_regs and sees only that module's ports. */
module cvj_regs_sva #(
   parameter int SAMPLE_W = 24
) (
   // Clock, reset and bus.
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_hsel,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic i_hready,
   // Controls and samples.
   input wire logic [7:0] o_right_dac_attenuation,
   input wire logic [7:0] o_left_adc_attenuation,
   input wire logic o_right_dac_mute,
   input wire logic o_left_adc_mute,
   input wire logic o_adc_highpass_on,
   input wire logic o_adc_highpass_mode,
   input wire logic [2:0] o_adc_highpass_cutoff,
   input wire logic i_adc_valid,
   input wire logic o_adc_valid,
   input wire logic [SAMPLE_W-1:0] o_right_adc_sample
);
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (i_rst);
   logic wr_taken;
   assign wr_taken = i_hsel && i_htrans == cvj_pkg::HTRANS_NONSEQ && i_hready && i_hwrite;
   a_rdac_mute_zero: assert property (o_right_dac_mute == (o_right_dac_attenuation == 8'h00))
      else $error("right DAC mute does not follow zero gain");
   a_ladc_mute_zero: assert property (o_left_adc_mute == (o_left_adc_attenuation == 8'h00))
      else $error("left ADC mute does not follow zero gain");
   a_cut_when_off: assert property (!o_adc_highpass_on |-> o_adc_highpass_cutoff == 3'h0)
      else $error("cutoff active with filter off");
   a_cut_first_order: assert property (!o_adc_highpass_mode |-> o_adc_highpass_cutoff == 3'h0)
      else $error("cutoff active in first order mode");
   a_sample_valid_delay: assert property (o_adc_valid == $past(i_adc_valid))
      else $error("sample strobe not one cycle late");
   a_sample_held: assert property (!i_adc_valid |=> $stable(o_right_adc_sample))
      else $error("sample changed without strobe");
   a_rdac_needs_write: assert property ($changed(o_right_dac_attenuation) |->
      $past(wr_taken, 2) || $past(wr_taken, 3) || $past(wr_taken, 4))
      else $error("right DAC gain changed without a write");
   a_ladc_needs_write: assert property ($changed(o_left_adc_attenuation) |->
      $past(wr_taken, 2) || $past(wr_taken, 3) || $past(wr_taken, 4))
      else $error("left ADC gain changed without a write");
endmodule : cvj_regs_sva

// *** tb/tb.sv ***
/* Self-checking bench for the volume, jack and ADC control bank.
   Assumes the host model drives the bus; the bench drives pins and samples. */
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SW = 24;
   logic i_ref_clk, i_rst, hsel, hwrite, hready, av, ov, hp, spk, aux1, aux2, hp_on, hp_mode, os;
   logic m_rd, m_ld, m_la, m_ra, hresp;
   logic [1:0] htrans;
   logic [2:0] hsize, cut, pins;
   logic [31:0] haddr, hwdata, hrdata;
   logic [7:0] rdac, ldac, ladc, radc;
   logic [SW-1:0] ls, rs, ols, ors;
   int err_count = 0;
   int samples_checked = 0;
   cvj_host host (.i_ref_clk(i_ref_clk), .i_hready(hready), .i_hrdata(hrdata), .o_hsel(hsel),
      .o_haddr(haddr), .o_htrans(htrans), .o_hwrite(hwrite), .o_hsize(hsize), .o_hwdata(hwdata));
   cvj_regs #(.SAMPLE_W(SW)) DUT (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_hsel(hsel), .i_haddr(haddr),
      .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
      .o_hreadyout(hready), .o_hresp(hresp), .o_hrdata(hrdata), .i_general_pin_one(pins[0]),
      .i_general_pin_two(pins[1]), .i_general_pin_three(pins[2]), .o_headphone_en(hp), .o_speaker_en(spk),
      .o_aux_line_out_two_en(aux2), .o_aux_line_out_one_en(aux1), .o_right_dac_attenuation(rdac),
      .o_left_dac_attenuation(ldac), .o_left_adc_attenuation(ladc), .o_right_adc_attenuation(radc),
      .o_right_dac_mute(m_rd), .o_left_dac_mute(m_ld), .o_left_adc_mute(m_la), .o_right_adc_mute(m_ra),
      .o_adc_highpass_on(hp_on), .o_adc_highpass_mode(hp_mode), .o_adc_highpass_cutoff(cut),
      .o_adc_oversample_select(os), .i_adc_valid(av), .i_left_adc_sample(ls), .i_right_adc_sample(rs),
      .o_adc_valid(ov), .o_left_adc_sample(ols), .o_right_adc_sample(ors));
   initial begin
      i_ref_clk = 1'b0;
      forever #10 i_ref_clk = ~i_ref_clk;
   end
   task automatic complete_run();
      $display("Checks %0d, mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : complete_run
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   function automatic logic [31:0] ad(input logic [5:0] i);
      return {24'h00_0000, i, 2'b00};
   endfunction : ad
   task automatic tick(input int n);
      repeat (n) @(posedge i_ref_clk);
      #1;
   endtask : tick
   task automatic xf(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
      logic ok;
      host.xfer(w, a, d, r, ok);
      if (!ok) begin
         err_count++;
         $display("[ERR] %0t bus answer timed out", $time);
         complete_run();
      end
   endtask : xf
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] r;
      xf(1'b1, a, d, r);
   endtask : wr
   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      logic [31:0] r;
      xf(1'b0, a, 32'h0000_0000, r);
      chk(r, e);
   endtask : rd
   task automatic t_reset();
      rd(ad(cvj_pkg::IDX_RDAC_VOL), 32'h0000_00ff);
      rd(ad(cvj_pkg::IDX_LADC_VOL), 32'h0000_00ff);
      rd(ad(cvj_pkg::IDX_JACK_OEN), 32'h0000_0000);
      rd(ad(cvj_pkg::IDX_ADC_CTRL), 32'h0000_0100);
      rd(32'h0000_0080, 32'h0000_0000);
      chk({31'h0000_0000, hresp}, 32'h0000_0000);
      chk({os, hp_on, rdac, ladc}, 32'h0000_ffff | 32'h0001_0000);
   endtask : t_reset
   task automatic t_dac();
      wr(ad(cvj_pkg::IDX_LDAC_VOL), 32'h0000_0012);
      wr(ad(cvj_pkg::IDX_RDAC_VOL), 32'h0000_0034);
      tick(3);
      chk({ldac, rdac}, 32'h0000_ffff);
      rd(ad(cvj_pkg::IDX_RDAC_VOL), 32'h0000_0034);
      wr(ad(cvj_pkg::IDX_RDAC_VOL), 32'h0000_0100);
      tick(3);
      chk({m_rd, ldac, rdac}, 32'h0001_1200);
      rd(ad(cvj_pkg::IDX_RDAC_VOL), 32'h0000_0000);
      wr(ad(cvj_pkg::IDX_LDAC_VOL), 32'h0000_0100);
      tick(3);
      chk({m_ld, m_rd, ldac, rdac}, 32'h0003_0000);
   endtask : t_dac
   task automatic t_adc();
      wr(ad(cvj_pkg::IDX_RADC_VOL), 32'h0000_0001);
      wr(ad(cvj_pkg::IDX_LADC_VOL), 32'h0000_0002);
      tick(3);
      chk({radc, ladc}, 32'h0000_ffff);
      wr(ad(cvj_pkg::IDX_LADC_VOL), 32'h0000_0102);
      tick(3);
      chk({m_la, m_ra, radc, ladc}, 32'h0000_0102);
      rd(ad(cvj_pkg::IDX_LADC_VOL), 32'h0000_0002);
      wr(ad(cvj_pkg::IDX_LADC_VOL), 32'h0000_0100);
      tick(3);
      chk({m_la, ladc}, 32'h0000_0100);
   endtask : t_adc
   task automatic jk(input logic [31:0] s, input logic [2:0] p, input logic [3:0] e);
      wr(ad(cvj_pkg::IDX_JACK_SEL), s);
      @(posedge i_ref_clk);
      pins <= p;
      tick(3);
      chk({aux1, aux2, spk, hp}, e);
   endtask : jk
   task automatic t_jack();
      wr(ad(cvj_pkg::IDX_JACK_OEN), 32'h0000_00a5);
      jk(32'h0000_0040, 3'b001, 4'b1010);
      rd(ad(cvj_pkg::IDX_JACK_SEL), 32'h0000_004a);
      jk(32'h0000_0040, 3'b000, 4'b0101);
      jk(32'h0000_0050, 3'b010, 4'b1010);
      jk(32'h0000_0060, 3'b011, 4'b0101);
      jk(32'h0000_0070, 3'b111, 4'b0000);
      jk(32'h0000_0000, 3'b111, 4'b0000);
   endtask : t_jack
   task automatic ctl(input logic [31:0] w, input logic [5:0] e);
      wr(ad(cvj_pkg::IDX_ADC_CTRL), w);
      tick(3);
      chk({hp_on, hp_mode, cut, os}, e);
      rd(ad(cvj_pkg::IDX_ADC_CTRL), w);
   endtask : ctl
   task automatic smp(input logic [31:0] c, input logic [SW-1:0] l, r, el, er);
      wr(ad(cvj_pkg::IDX_ADC_CTRL), c);
      @(posedge i_ref_clk);
      av <= 1'b1;
      ls <= l;
      rs <= r;
      @(posedge i_ref_clk);
      av <= 1'b0;
      ls <= ~l;
      rs <= ~r;
      #1;
      chk({31'h0000_0000, ov}, 32'h0000_0001);
      chk({8'h00, ols}, {8'h00, el});
      chk({8'h00, ors}, {8'h00, er});
   endtask : smp
   initial begin
      i_rst = 1'b1;
      av = 1'b0;
      ls = '0;
      rs = '0;
      pins = 3'b000;
      repeat (10) @(posedge i_ref_clk);
      i_rst <= 1'b0;
      t_reset();
      t_dac();
      t_adc();
      t_jack();
      ctl(32'h0000_00f8, 6'b010001);
      ctl(32'h0000_01f8, 6'b111111);
      ctl(32'h0000_0170, 6'b100000);
      smp(32'h0000_0100, 24'h00_0005, 24'h00_0005, 24'h00_0005, 24'h00_0005);
      smp(32'h0000_0102, 24'h00_0005, 24'h80_0000, 24'h00_0005, 24'h7f_ffff);
      smp(32'h0000_0101, 24'h00_0003, 24'h00_0005, 24'hff_fffd, 24'h00_0005);
      complete_run();
   end
endmodule : tb
bind cvj_regs cvj_regs_sva #(.SAMPLE_W(SAMPLE_W)) u_sva (.i_ref_clk, .i_rst, .i_hsel, .i_htrans, .i_hwrite,
   .i_hready, .o_right_dac_attenuation, .o_left_adc_attenuation, .o_right_dac_mute, .o_left_adc_mute,
   .o_adc_highpass_on, .o_adc_highpass_mode, .o_adc_highpass_cutoff, .i_adc_valid, .o_adc_valid,
   .o_right_adc_sample);
